//--- lals_pkg.sv
// Contract
// - keep integrator capacitors cleared whenever no line sequence runs.
// - trigger rising edge opens the charge-clear switch, integration begins.
// - reference sample-hold of active bank asserted 38.5 clocks after trigger rises (code asserts it from the rise for 39 clocks, REF_SH_CLKS).
// - trigger falling edge asserts active bank signal sample-hold.
// - after signal sample, close the clear switch and drain capacitors.
// - after trigger falls, run readout presenting reference and signal per pixel.
// - alternate two sample-hold banks on successive lines.
// - external timing mode: follow external sample and line-sync inputs.
// - select one of four feedback capacitances from the loaded mode setting.
// - two-sided arrays: odd pixels right pair, even pixels left pair.
// - readout on 1, 2, 4 or 8 parallel outputs.
// - internal timing: integration starts after reference sample, 38.5 clocks shorter (code: 39 clocks shorter, REF_SH_CLKS).
// - at least 8 overhead clocks per line, line time at least 136 clocks.
// - trigger transitions, line sync and pixels change once per clock.
// - reset held 2 clocks; default mode one clock after release.
`default_nettype none
package lals_pkg;

   localparam int CLK_MHZ          = 50;
   localparam int REF_SH_HALF_CLKS = 77;
   localparam int REF_SH_CLKS      = (REF_SH_HALF_CLKS + 1) / 2;
   localparam int SIG_SH_CLKS      = 2;
   localparam int OVERHEAD_CLKS    = 8;
   localparam int MIN_LINE_CLKS    = 136;
   localparam int PIX_W            = 11;
   localparam int CNT_W            = 6;
   localparam int MAX_LANES        = 8;

   localparam logic [PIX_W-1:0] LEN_256  = 11'h100;
   localparam logic [PIX_W-1:0] LEN_512  = 11'h200;
   localparam logic [PIX_W-1:0] LEN_1024 = 11'h400;

   typedef enum logic [1:0] {LALS_CAP_013P, LALS_CAP_1P, LALS_CAP_10P, LALS_CAP_20P} lals_cap_e;
   typedef enum logic [1:0] {LALS_OUT_1, LALS_OUT_2, LALS_OUT_4, LALS_OUT_8} lals_outs_e;
   typedef enum logic [1:0] {LALS_LEN_256, LALS_LEN_512, LALS_LEN_1024, LALS_LEN_RSVD} lals_len_e;

   typedef struct packed {
      lals_cap_e  cap_sel;
      lals_outs_e out_sel;
      lals_len_e  len_sel;
      logic       two_sided;
      logic       ext_mode;
   } lals_cfg_s;

   typedef struct packed {
      logic ref_sh;
      logic sig_sh;
      logic line_sync;
   } lals_ext_s;

   typedef struct packed {
      logic                 valid;
      logic                 sync;
      logic                 bank;
      logic [PIX_W-1:0]     pixel;
      logic [3:0]           lanes;
      logic [MAX_LANES-1:0] lane_en;
      logic [MAX_LANES-1:0] right_mask;
   } lals_video_s;

   function automatic logic [3:0] lals_lanes(input lals_outs_e sel);
      return 4'h1 << sel;
   endfunction

   function automatic logic [PIX_W-1:0] lals_len(input lals_len_e sel);
      case (sel)
         LALS_LEN_256:  return LEN_256;
         LALS_LEN_512:  return LEN_512;
         default:       return LEN_1024;
      endcase
   endfunction

endpackage
`default_nettype wire

//--- lals_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module lals_sequencer (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_line_trigger,
   input  wire logic              i_cfg_load,
   input  wire lals_pkg::lals_cfg_s i_cfg,
   input  wire lals_pkg::lals_ext_s i_ext,
   output logic                   o_mode_ready,
   output logic                   o_integrator_clear,
   output logic                   o_reference_sample_hold,
   output logic                   o_alt_reference_sample_hold,
   output logic                   o_signal_sample_hold,
   output logic                   o_alt_signal_sample_hold,
   output lals_pkg::lals_cap_e    o_cap_sel,
   output lals_pkg::lals_video_s  o_video
);
   import lals_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_REF, ST_INTEG, ST_SIG} lals_state_e;

   ////////////////////////////////////////////////////////////////////////////
   lals_state_e       state_r, state_nxt;
   logic [CNT_W-1:0]  cnt_r, cnt_nxt;
   logic              trig_d_r;
   logic              ext_sync_d_r;
   logic              ready_r;
   lals_cfg_s         cfg_r;
   logic              sample_bank_r;
   logic              read_bank_r;
   logic              rd_busy_r;
   logic [3:0]        ovh_r;
   logic [PIX_W-1:0]  pix_r;
   logic              clear_r, ref_r, sig_r;
   lals_video_s       video_r, video_nxt;

   wire trig_rise  = i_line_trigger & ~trig_d_r;
   wire trig_fall  = ~i_line_trigger & trig_d_r;
   wire line_start = (state_r == ST_IDLE) & trig_rise & ready_r;
   wire ref_done   = (cnt_r == CNT_W'(REF_SH_CLKS - 1));
   wire sig_done   = (cnt_r == CNT_W'(SIG_SH_CLKS - 1));
   wire ext_sync_rise = i_ext.line_sync & ~ext_sync_d_r;
   // sequence flags and start pulse come from the internal machine or the pins
   wire ref_int   = cfg_r.ext_mode ? i_ext.ref_sh : (state_nxt == ST_REF);
   wire sig_int   = cfg_r.ext_mode ? i_ext.sig_sh : (state_nxt == ST_SIG);
   wire start_rd  = cfg_r.ext_mode ? ext_sync_rise : ((state_r == ST_SIG) & sig_done);
   wire bank_nxt  = line_start ? ~sample_bank_r : sample_bank_r;
   wire [3:0]       lanes   = lals_lanes(cfg_r.out_sel);
   wire [PIX_W-1:0] len     = lals_len(cfg_r.len_sel);
   wire [PIX_W:0]   pix_end = {1'b0, pix_r} + {{(PIX_W-3){1'b0}}, lanes};
   wire             last_px = (pix_end >= {1'b0, len});
   wire             emit    = rd_busy_r & (ovh_r == 4'(OVERHEAD_CLKS - 1));

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:  if (line_start) state_nxt = ST_REF;
         ST_REF: begin
            if (trig_fall) state_nxt = ST_SIG;
            else if (ref_done && !cfg_r.ext_mode) state_nxt = ST_INTEG;
         end
         ST_INTEG: if (trig_fall) state_nxt = ST_SIG;
         ST_SIG:   if (sig_done) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   assign cnt_nxt = (state_nxt != state_r) ? '0 : (&cnt_r ? cnt_r : cnt_r + 1'b1);

   // lane k carries pixel pix_r+k; numbers count from one, so even index is odd pixel
   always_comb begin
      video_nxt            = '0;
      video_nxt.sync       = start_rd;
      video_nxt.bank       = start_rd ? sample_bank_r : read_bank_r;
      video_nxt.lanes      = lanes;
      video_nxt.valid      = emit;
      video_nxt.pixel      = emit ? pix_r : '0;
      for (int k = 0; k < MAX_LANES; k++) begin
         video_nxt.lane_en[k]    = emit & (4'(k) < lanes);
         video_nxt.right_mask[k] = emit & (4'(k) < lanes) & (~cfg_r.two_sided | ~(pix_r[0] ^ k[0]));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // default mode needs one clock after release
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) ready_r <= 1'b0;
      else ready_r <= 1'b1;
   end

   // config only changes between lines so a running sequence is not torn
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) cfg_r <= '0;
      else if (i_cfg_load && state_r == ST_IDLE && !rd_busy_r) cfg_r <= i_cfg;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r       <= ST_IDLE;
         cnt_r         <= '0;
         trig_d_r      <= 1'b0;
         ext_sync_d_r  <= 1'b0;
         sample_bank_r <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         cnt_r         <= cnt_nxt;
         trig_d_r      <= i_line_trigger;
         ext_sync_d_r  <= i_ext.line_sync;
         sample_bank_r <= bank_nxt;
      end
   end

   // pin-facing controls come from flops, the four sample-holds as ref_r/sig_r gated by sample_bank_r, one change per clock at most
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         clear_r <= 1'b1;
         ref_r   <= 1'b0;
         sig_r   <= 1'b0;
         video_r <= '0;
      end else begin
         clear_r <= (state_nxt == ST_IDLE);
         ref_r   <= ref_int;
         sig_r   <= sig_int;
         video_r <= video_nxt;
      end
   end

   // a new start restarts readout; the line time keeps that from cutting a line short
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_busy_r   <= 1'b0;
         read_bank_r <= 1'b0;
         ovh_r       <= '0;
         pix_r       <= '0;
      end else if (start_rd) begin
         rd_busy_r   <= 1'b1;
         read_bank_r <= sample_bank_r;
         ovh_r       <= '0;
         pix_r       <= '0;
      end else if (rd_busy_r) begin
         if (!emit) ovh_r <= ovh_r + 1'b1;
         else begin
            pix_r <= pix_end[PIX_W-1:0];
            if (last_px) rd_busy_r <= 1'b0;
         end
      end
   end

   assign o_mode_ready                = ready_r;
   assign o_integrator_clear          = clear_r;
   assign o_reference_sample_hold     = ref_r & ~sample_bank_r;
   assign o_alt_reference_sample_hold = ref_r & sample_bank_r;
   assign o_signal_sample_hold        = sig_r & ~sample_bank_r;
   assign o_alt_signal_sample_hold    = sig_r & sample_bank_r;
   assign o_cap_sel                   = cfg_r.cap_sel;
   assign o_video                     = video_r;

   ////////////////////////////////////////////////////////////////////////////
   logic [CNT_W-1:0] ref_len_r;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) ref_len_r <= '0;
      else ref_len_r <= ref_r ? ref_len_r + 1'b1 : '0;
   end

   property p_clear_idle;
      @(posedge i_clk) disable iff (i_rst) (state_r == ST_IDLE) |-> o_integrator_clear;
   endproperty
   a_clear_idle: assert property (p_clear_idle) else $error("integrator not cleared while idle");

   property p_open_on_rise;
      @(posedge i_clk) disable iff (i_rst) line_start |=> !o_integrator_clear;
   endproperty
   a_open_on_rise: assert property (p_open_on_rise) else $error("clear switch not opened on trigger rise");

   property p_ref_width;
      @(posedge i_clk) disable iff (i_rst) $fell(ref_r) && state_r == ST_INTEG |-> ref_len_r == CNT_W'(REF_SH_CLKS);
   endproperty
   a_ref_width: assert property (p_ref_width) else $error("reference sample width wrong");

   property p_sig_on_fall;
      @(posedge i_clk) disable iff (i_rst)
         trig_fall && !cfg_r.ext_mode && (state_r == ST_REF || state_r == ST_INTEG) |=> sig_r [*2] ##1 !sig_r;
   endproperty
   a_sig_on_fall: assert property (p_sig_on_fall) else $error("signal sample not taken on trigger fall");

   property p_clear_after_sig;
      @(posedge i_clk) disable iff (i_rst) $fell(sig_r) && !cfg_r.ext_mode |-> o_integrator_clear;
   endproperty
   a_clear_after_sig: assert property (p_clear_after_sig) else $error("clear not closed after signal sample");

   property p_sync_then_video;
      @(posedge i_clk) disable iff (i_rst)
         o_video.sync ##1 !o_video.sync [*8] |-> o_video.valid && o_video.pixel == '0;
   endproperty
   a_sync_then_video: assert property (p_sync_then_video) else $error("first pixel not after overhead");

   property p_bank_alt;
      @(posedge i_clk) disable iff (i_rst) line_start |=> sample_bank_r != $past(sample_bank_r);
   endproperty
   a_bank_alt: assert property (p_bank_alt) else $error("bank did not alternate");

   property p_right_odd;
      @(posedge i_clk) disable iff (i_rst)
         o_video.valid && cfg_r.two_sided |-> o_video.right_mask[0] == ~o_video.pixel[0];
   endproperty
   a_right_odd: assert property (p_right_odd) else $error("odd pixel not on right side");

   property p_lanes;
      @(posedge i_clk) disable iff (i_rst)
         o_video.valid |-> o_video.lane_en == 8'((9'h001 << o_video.lanes) - 9'h001);
   endproperty
   a_lanes: assert property (p_lanes) else $error("lane enables disagree with lane count");

   property p_stop;
      @(posedge i_clk) disable iff (i_rst) emit && last_px && !start_rd |=> !rd_busy_r ##1 !o_video.valid;
   endproperty
   a_stop: assert property (p_stop) else $error("readout did not stop at last pixel");

   property p_ready;
      @(posedge i_clk) disable iff (i_rst) !ready_r |=> ready_r;
   endproperty
   a_ready: assert property (p_ready) else $error("default mode not entered one clock after reset");

   c_line_internal: cover property (@(posedge i_clk) disable iff (i_rst) state_r == ST_INTEG ##[1:1000] state_r == ST_SIG);
   c_line_ext:      cover property (@(posedge i_clk) disable iff (i_rst) cfg_r.ext_mode && start_rd);
   c_eight_lanes:   cover property (@(posedge i_clk) disable iff (i_rst) o_video.valid && o_video.lanes == 4'h8);
   c_read_end:      cover property (@(posedge i_clk) disable iff (i_rst) emit && last_px);

endmodule
`default_nettype wire

//--- lals_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lals_ctrl_model (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_go,
   input  wire logic [15:0]           i_high,
   input  wire logic [15:0]           i_low,
   input  wire lals_pkg::lals_video_s i_video,
   output logic                       o_line_trigger,
   output logic                       o_busy,
   output logic [15:0]                o_nvalid,
   output logic [15:0]                o_step_err
);
   import lals_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic [15:0]      cnt_r;
   logic [PIX_W-1:0] next_r;

   // trigger high for i_high clocks, then held low for i_low before next go
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_line_trigger <= 1'b0;
         o_busy         <= 1'b0;
         cnt_r          <= '0;
      end else if (i_go && !o_busy) begin
         o_line_trigger <= 1'b1;
         o_busy         <= 1'b1;
         cnt_r          <= i_high;
      end else if (o_busy && cnt_r == 16'h1) begin
         o_line_trigger <= 1'b0;
         o_busy         <= o_line_trigger;
         cnt_r          <= i_low;
      end else if (o_busy) begin
         cnt_r <= cnt_r - 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // digitizer side: counts valid words, flags gaps in the pixel sequence
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_nvalid   <= '0;
         o_step_err <= '0;
         next_r     <= '0;
      end else if (i_video.sync) begin
         o_nvalid <= '0;
         next_r   <= '0;
      end else if (i_video.valid) begin
         o_nvalid <= o_nvalid + 16'h1;
         if (i_video.pixel !== next_r) begin
            o_step_err <= o_step_err + 16'h1;
         end
         next_r <= i_video.pixel + PIX_W'(i_video.lanes);
      end
   end
endmodule
`default_nettype wire

//--- lals_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lals_sequencer_tb_top;
   import lals_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic        clk = 1'b0, rst = 1'b1, go = 1'b0, load = 1'b0, trig, busy;
   logic        mode_ready, clr, ref0, ref1, sig0, sig1, got_first, ref_bank, vid_bank, prev_bank;
   lals_cfg_s   cfg = '0;
   lals_ext_s   ext = '0;
   lals_cap_e   cap;
   lals_video_s vid, first_vid;
   logic [15:0] high = 16'd60, low = 16'd100, cyc = '0;
   logic [15:0] nvalid, step_err, n_ref, n_sig, n_clr, n_sync;
   int          n_errors = 0, checks = 0, nline = 0;
   // last row runs in external timing mode
   lals_cfg_s   rows [6] = '{8'h30, 8'h42, 8'h96, 8'he8, 8'h7e, 8'h31};
   logic [15:0] npix [6] = '{16'd32, 16'd256, 16'd256, 16'd256, 16'd128, 16'd32};

   // the block counts clocks only; the 20 ns bench clock matches the 50 MHz of CLK_MHZ
   always #10 clk = ~clk;

   lals_sequencer lals_sequencer_inst (.i_clk(clk), .i_rst(rst), .i_line_trigger(trig), .i_cfg_load(load),
      .i_cfg(cfg), .i_ext(ext), .o_mode_ready(mode_ready), .o_integrator_clear(clr),
      .o_reference_sample_hold(ref0), .o_alt_reference_sample_hold(ref1), .o_signal_sample_hold(sig0),
      .o_alt_signal_sample_hold(sig1), .o_cap_sel(cap), .o_video(vid));
   lals_ctrl_model lals_ctrl_model_inst (.i_clk(clk), .i_rst(rst), .i_go(go), .i_high(high), .i_low(low),
      .i_video(vid), .o_line_trigger(trig), .o_busy(busy), .o_nvalid(nvalid), .o_step_err(step_err));

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 16'h1;
      if (cyc == 16'd20000) begin
         n_errors++;
         conclude();
      end
      if (go) begin
         n_ref     <= '0;
         n_sig     <= '0;
         n_clr     <= '0;
         n_sync    <= '0;
         got_first <= 1'b0;
      end else begin
         n_ref  <= n_ref + 16'(ref0 | ref1);
         n_sig  <= n_sig + 16'(sig0 | sig1);
         n_clr  <= n_clr + 16'(!clr);
         n_sync <= n_sync + 16'(vid.sync);
         if (ref0 || ref1) ref_bank <= ref1;
         if (vid.sync) vid_bank <= vid.bank;
         if (vid.valid && !got_first) begin
            first_vid <= vid;
            got_first <= 1'b1;
         end
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic conclude();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk_reset();
      chk("rst_clear", 16'h1, 16'(clr));
      chk("rst_ready", 16'h0, 16'(mode_ready));
      chk("rst_sh", 16'h0, 16'({ref0, ref1, sig0, sig1}));
      chk("rst_video", 16'h0, 16'(|vid));
      chk("rst_cap", 16'h0, 16'(cap));
   endtask

   // one full line; a late config load is tried in mid-readout and must be ignored
   task automatic run_line(input lals_cfg_s c, input logic [15:0] n);
      logic [7:0] en;
      en = 8'((16'h1 << (16'h1 << c.out_sel)) - 16'h1);
      @(posedge clk);
      cfg  <= c;
      load <= 1'b1;
      low  <= n + 16'd80;
      @(posedge clk);
      load <= 1'b0;
      go   <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      #1;
      chk("clear_idle", 16'h1, 16'(clr));
      for (int k = 0; k < 4000 && busy; k++) begin
         @(posedge clk);
         load <= (k == 90);
         if (k == 90) cfg <= ~c;
         if (c.ext_mode) ext <= lals_ext_s'({k >= 5 && k < 10, k >= 70 && k < 73, k == 80});
      end
      ext <= '0;
      #1;
      chk("ref_width", c.ext_mode ? 16'd5 : 16'(REF_SH_CLKS), n_ref);
      chk("sig_width", c.ext_mode ? 16'd3 : 16'(SIG_SH_CLKS), n_sig);
      if (!c.ext_mode) chk("clear_low", high + 16'd2, n_clr);
      chk("sync_count", 16'h1, n_sync);
      chk("pixels", n, nvalid);
      chk("pixel_order", 16'h0, step_err);
      chk("first_pixel", 16'h0, 16'(first_vid.pixel));
      chk("lanes", 16'h1 << c.out_sel, 16'(first_vid.lanes));
      chk("lane_en", 16'(en), 16'(first_vid.lane_en));
      chk("right_mask", 16'(c.two_sided ? en & 8'h55 : en), 16'(first_vid.right_mask));
      chk("cap_sel", 16'(c.cap_sel), 16'(cap));
      chk("read_bank", 16'(ref_bank), 16'(vid_bank));
      if (nline > 0) chk("bank_toggle", 16'(!prev_bank), 16'(vid_bank));
      chk("clear_end", 16'h1, 16'(clr));
      chk("valid_end", 16'h0, 16'(vid.valid));
      prev_bank = vid_bank;
      nline++;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      #1;
      chk_reset();
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("ready", 16'h1, 16'(mode_ready));
      for (int r = 0; r < 6; r++) run_line(rows[r], npix[r]);
      // reset in mid-line, then a plain line afterwards
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (30) @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_reset();
      @(posedge clk);
      rst <= 1'b0;
      nline = 0;
      run_line(rows[0], npix[0]);
      conclude();
   end
endmodule
`default_nettype wire
